// ### dv/swsl_master.sv
/* master model for the single-wire link: pull-up, open-drain pull,
   reset pulse and bit/byte slots.
   assumes the shortened slot delays of the bench (8 cycles). */
`timescale 1ns/1ps
module swsl_master #(
    parameter int RST = 48
) (
    input  wire logic i_ref_clk, // clock
    input  wire logic i_dev_oe,  // device pulls low
    output logic      o_line     // resolved line level
);
    logic low_q = 1'b0;
    // pull-up wins whenever nobody pulls the line low
    assign o_line = ~(low_q | i_dev_oe);
    task automatic reset_pulse();
        @(posedge i_ref_clk);
        #1 low_q = 1'b1;
        repeat (RST) @(posedge i_ref_clk);
        #1 low_q = 1'b0;
    endtask
    // a logic line cannot show the 12 V level: the pulse keeps it released
    task automatic prog_pulse();
        @(posedge i_ref_clk);
        #1 low_q = 1'b0;
        repeat (RST) @(posedge i_ref_clk);
    endtask
    // short low for a one or a read, long low for a zero
    task automatic slot(input logic b, output logic s);
        @(posedge i_ref_clk);
        #1 low_q = 1'b1;
        @(posedge i_ref_clk);
        #1 low_q = ~b;
        repeat (3) @(posedge i_ref_clk);
        #2 s = o_line;
        repeat (8) @(posedge i_ref_clk);
        #1 low_q = 1'b0;
        repeat (4) @(posedge i_ref_clk);
    endtask
    task automatic wr_byte(input logic [7:0] b);
        logic s;
        for (int i = 0; i < 8; i++)
            slot(b[i], s);
    endtask
    task automatic rd_byte(output logic [7:0] b);
        for (int i = 0; i < 8; i++)
            slot(1'b1, b[i]);
    endtask
endmodule

// ### dv/tb_swsl_link.sv
/* testbench for swsl_link: presence, slots, tx fifo, crc16 and crc8.
   assumes shortened delays: reset 40, wait 10, presence 20, slots 8. */
`timescale 1ns/1ps
module tb_swsl_link;
    import swsl_pkg::*;
    localparam int PW = 10;
    localparam int PR = 20;
    logic               i_ref_clk = 1'b0;
    logic               i_rst = 1'b1;
    logic               i_dq;
    logic               o_dq_oe;
    logic               o_dq;
    logic [1:0]         i_src_sel = 2'h_3;
    logic [7:0]         i_tx_data = 8'h_00;
    logic               i_tx_valid = 1'b0;
    logic               o_tx_ready;
    logic [7:0]         o_rx_data;
    logic               o_rx_valid;
    logic               o_rom_ready;
    logic               o_concealed;
    logic               i_crc_clr = 1'b0;
    logic               i_crc_load = 1'b0;
    logic [15:0]        i_crc_load_val = 16'h_0000;
    logic               i_crc_send = 1'b0;
    logic               i_chan_start = 1'b0;
    logic [1:0]         i_chan_sel = 2'h_0;
    logic [ID_BITS-1:0] i_id = 56'h_00A1_B2C3_D4E5_F6;
    logic [7:0]         o_id_crc8;
    logic [7:0]         rx_last;
    int                 error_cnt = 0;
    int                 comparisons = 0;
    int                 cycles = 0;

    swsl_link #(.RST_CYC(40), .PWAIT_CYC(PW), .PRES_CYC(PR),
                .SMPL_CYC(8), .HLD_CYC(8)) swsl_link_i (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_dq(i_dq), .o_dq(o_dq),
        .o_dq_oe(o_dq_oe), .i_src_sel(i_src_sel),
        .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid),
        .o_tx_ready(o_tx_ready), .o_rx_data(o_rx_data),
        .o_rx_valid(o_rx_valid), .o_rom_ready(o_rom_ready),
        .o_concealed(o_concealed), .i_crc_clr(i_crc_clr),
        .i_crc_load(i_crc_load), .i_crc_load_val(i_crc_load_val),
        .i_crc_send(i_crc_send), .i_chan_start(i_chan_start),
        .i_chan_sel(i_chan_sel), .i_id(i_id), .o_id_crc8(o_id_crc8));
    swsl_master swsl_master_i (.i_ref_clk(i_ref_clk),
        .i_dev_oe(o_dq_oe), .o_line(i_dq));

    initial forever #2.5 i_ref_clk = ~i_ref_clk;

    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // the full run is near 10k cycles
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (o_rx_valid === 1'b1)
            rx_last = o_rx_data;
        if (cycles == 30000)
        begin
            error_cnt++;
            close_out();
        end
    end

    function automatic logic [15:0] crc16(input logic [15:0] c,
                                          input logic [7:0]  b);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'h_A001) : (c >> 1);
        return c;
    endfunction

    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h_00;
        for (int i = 0; i < 56; i++)
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h_8C) : (c >> 1);
        return c;
    endfunction

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] s);
        comparisons++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic pulse(ref logic s);
        @(posedge i_ref_clk);
        #1 s = 1'b1;
        @(posedge i_ref_clk);
        #1 s = 1'b0;
    endtask

    task automatic crc_rd(input string n, input logic [15:0] c);
        logic [7:0] lo;
        logic [7:0] hi;
        swsl_master_i.rd_byte(lo);
        swsl_master_i.rd_byte(hi);
        chk(n, ~c, {hi, lo});
    endtask

    task automatic t_reset(input logic pres);
        int   w;
        int   p;
        logic rdy;
        w = 0;
        p = 0;
        rdy = 1'b0;
        swsl_master_i.reset_pulse();
        while ((!rdy || o_dq_oe === 1'b1) && w + p < 200)
        begin
            @(posedge i_ref_clk);
            #1;
            if (o_dq_oe === 1'b1)
                p++;
            else if (p == 0)
                w++;
            if (o_rom_ready === 1'b1)
                rdy = 1'b1;
        end
        chk("rom ready", 16'h_0001, {15'h_0, rdy});
        chk("presence", {15'h_0, pres},
            {15'h_0, p >= PR - 1 && p <= PR + 1});
        chk("dq value", 16'h_0000, {15'h_0, o_dq});
        if (pres)
            chk("wait", 16'h_0001, {15'h_0, w >= PW && w <= PW + 3});
    endtask

    task automatic t_fifo();
        logic [7:0] b;
        int         n;
        n = 0;
        @(posedge i_ref_clk);
        #1;
        while (o_tx_ready === 1'b1 && n < 12)
        begin
            i_tx_data = 8'(n * 37 + 5);
            i_tx_valid = 1'b1;
            @(posedge i_ref_clk);
            #1 n++;
        end
        i_tx_valid = 1'b0;
        chk("fifo depth", 16'h_0001, {15'h_0, n == 8 || n == 9});
        for (int i = 0; i < n; i++)
        begin
            swsl_master_i.rd_byte(b);
            chk("tx byte", {8'h_00, 8'(i * 37 + 5)}, {8'h_00, b});
        end
        chk("fifo room", 16'h_0001, {15'h_0, o_tx_ready});
    endtask

    task automatic t_crc();
        logic [15:0] c;
        logic [7:0]  cmd [4] = '{8'h_55, 8'h_10, 8'h_00, 8'h_A7};
        c = 16'h_0000;
        pulse(i_crc_clr);
        foreach (cmd[i])
        begin
            swsl_master_i.wr_byte(cmd[i]);
            c = crc16(c, cmd[i]);
        end
        pulse(i_crc_send);
        crc_rd("crc write", c);
        swsl_master_i.prog_pulse();
        i_crc_load_val = 16'h_0011;
        pulse(i_crc_load);
        swsl_master_i.wr_byte(8'h_3E);
        pulse(i_crc_send);
        crc_rd("crc load", crc16(16'h_0011, 8'h_3E));
    endtask

    // every interval code; with none the next read slots see all ones
    task automatic t_chan();
        int          n [4] = '{1, 1, 8, 32};
        logic [15:0] c;
        for (int s = 0; s < 4; s++)
        begin
            c = 16'h_0000;
            i_chan_sel = 2'(s);
            pulse(i_crc_clr);
            pulse(i_chan_start);
            for (int k = 0; k < n[s]; k++)
            begin
                swsl_master_i.wr_byte(8'(k * 29 + s));
                c = crc16(c, 8'(k * 29 + s));
            end
            if (s == 0)
                crc_rd("no crc", 16'h_0000);
            else
                crc_rd("chan crc", c);
        end
    endtask

    task automatic t_conceal();
        @(posedge i_ref_clk);
        #1 i_src_sel = 2'h_0;
        i_rst = 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1 chk("concealed", 16'h_0001, {15'h_0, o_concealed});
        t_reset(1'b1);
        t_reset(1'b0);
    endtask

    initial
    begin
        logic [7:0] b;
        repeat (16) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1 chk("id crc8", {8'h_00, crc8(i_id)},
               {8'h_00, o_id_crc8});
        t_reset(1'b1);
        chk("visible", 16'h_0000, {15'h_0, o_concealed});
        swsl_master_i.wr_byte(8'h_3C);
        chk("rx byte", 16'h_003C, {8'h_00, rx_last});
        t_fifo();
        t_crc();
        t_chan();
        t_conceal();
        close_out();
    end
endmodule

// ### rtl/swsl_link.sv
/*
 * single-wire slave link: reset/presence, read and write slots, crc16
 * stream generator with channel crc intervals, tx byte fifo, id crc8.
 * assumes the line input is already synchronous to i_ref_clk and that an
 * outside pull-up resolves the open-drain line from o_dq / o_dq_oe.
 */
`timescale 1ns/1ps

module swsl_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         i_ref_clk,   // clock
    input  wire logic         i_rst,       // sync reset
    input  wire logic [W-1:0] i_in_data,   // fill data
    input  wire logic         i_in_valid,  // fill valid
    output logic              o_in_ready,  // not full
    output logic [W-1:0]      o_out_data,  // head word
    output logic              o_out_valid, // not empty
    input  wire logic         i_out_ready  // drain
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;
    logic [AW:0]   cnt_d;

    assign push = i_in_valid && o_in_ready;
    assign pop  = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_q];
    assign o_out_valid = (cnt_q != '0);
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge i_ref_clk)
    begin
        if (push)
        begin
            mem[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            wr_q       <= '0;
            rd_q       <= '0;
            cnt_q      <= '0;
            o_in_ready <= 1'b0;
        end
        else
        begin
            wr_q       <= push ? AW'(wr_q + 1'b1) : wr_q;
            rd_q       <= pop ? AW'(rd_q + 1'b1) : rd_q;
            cnt_q      <= cnt_d;
            o_in_ready <= (cnt_d != (AW+1)'(D));
        end
    end
endmodule

// Contract
// - presence after 15-60 us, lasting 60-240 us
// - finished reset exchange readies for command byte
// - concealed device gives presence once per power-up
// - falling edge starts delay; write slots sampled then
// - read zero holds line low; one untouched
// - identity top byte is uninverted crc8
// - crc16 polynomial, always sent complemented
// - memory read crc after last byte
// - status read crc after 8-byte page
// - extended read crc after each redirection byte
// - page-end crc covers page data only
// - write crc covers command, address, data
// - later write passes load incremented address
// - channel crc interval none, 1, 8, 32
// - channel crcs clear and cover new data
// - crc mismatch never stalls the sequence
// - both source-select bits zero means concealed
module swsl_link
    import swsl_pkg::*;
#(
    parameter int RST_CYC   = swsl_pkg::RESET_LOW_CYC,
    parameter int PWAIT_CYC = swsl_pkg::PRESENCE_WAIT_CYC,
    parameter int PRES_CYC  = swsl_pkg::PRESENCE_LOW_CYC,
    parameter int SMPL_CYC  = swsl_pkg::SAMPLE_CYC,
    parameter int HLD_CYC   = swsl_pkg::HOLD_CYC
) (
    input  wire logic                 i_ref_clk,     // 200 MHz clock
    input  wire logic                 i_rst,         // sync reset
    input  wire logic                 i_dq,          // line level
    output logic                      o_dq,          // line drive value
    output logic                      o_dq_oe,       // pull line low
    input  wire logic [1:0]           i_src_sel,     // status byte 6 bits 2:1
    input  wire logic [7:0]           i_tx_data,     // byte to send
    input  wire logic                 i_tx_valid,    // tx byte valid
    output logic                      o_tx_ready,    // tx fifo room
    output logic [7:0]                o_rx_data,     // received byte
    output logic                      o_rx_valid,    // rx byte pulse
    output logic                      o_rom_ready,   // reset done pulse
    output logic                      o_concealed,   // concealed mode
    input  wire logic                 i_crc_clr,     // clear generator
    input  wire logic                 i_crc_load,    // load address
    input  wire logic [15:0]          i_crc_load_val,// address to load
    input  wire logic                 i_crc_send,    // queue crc now
    input  wire logic                 i_chan_start,  // channel data begins
    input  wire logic [1:0]           i_chan_sel,    // channel crc interval
    input  wire logic [ID_BITS-1:0]   i_id,          // identity low bits
    output logic [7:0]                o_id_crc8      // identity crc byte
);
    import swsl_pkg::*;

    typedef enum logic [2:0] {
        SWSL_IDLE, SWSL_SLOT, SWSL_PWAIT, SWSL_PRES
    } swsl_state_type;

    function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                               input logic [7:0]  b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [5:0] interval_len(input logic [1:0] s);
        case (swsl_crc_sel_type'(s))
            SWSL_CRC_EVERY_1:  return INTERVAL_1;
            SWSL_CRC_EVERY_8:  return INTERVAL_8;
            SWSL_CRC_EVERY_32: return INTERVAL_32;
            default:           return '0;
        endcase
    endfunction

    swsl_state_type st_q;
    logic [CNT_W-1:0] cnt_q;
    logic        dq_prev_q;
    logic        low_run_q;
    logic        rst_seen_q;
    logic        cap_q;
    logic        pres_done_q;
    logic [7:0]  tx_sh_q;
    logic [7:0]  tx_byte_q;
    logic [3:0]  tx_cnt_q;
    logic        tx_is_crc_q;
    logic [2:0]  rx_cnt_q;
    logic [7:0]  rx_sh_q;
    logic [15:0] crc_q;
    logic [15:0] crc_out_q;
    logic [1:0]  pend_q;
    logic        chan_on_q;
    logic [1:0]  chan_sel_q;
    logic [5:0]  byte_cnt_q;
    logic        auto_due_q;
    logic [7:0]  fifo_data;
    logic        fifo_valid;
    logic        fifo_pop;
    logic        fall;
    logic        tx_act;
    logic        bit_take;
    logic        bit_send;
    logic        slot_done;
    logic        byte_ev;
    logic [7:0]  byte_val;
    logic        send_go;
    logic        pres_ok;

    assign fall      = dq_prev_q && !i_dq;
    assign tx_act    = (tx_cnt_q != '0);
    // one counter serves both slot kinds
    assign bit_take  = (st_q == SWSL_SLOT) && !tx_act
                       && (cnt_q == CNT_W'(SMPL_CYC));
    assign bit_send  = (st_q == SWSL_SLOT) && tx_act
                       && (cnt_q == CNT_W'(HLD_CYC));
    assign slot_done = (cnt_q > CNT_W'(SMPL_CYC))
                       && (cnt_q > CNT_W'(HLD_CYC));
    assign pres_ok   = !o_concealed || !pres_done_q;
    assign fifo_pop  = (st_q == SWSL_IDLE) && !tx_act && (pend_q == '0);
    assign send_go   = (i_crc_send || auto_due_q) && (pend_q == '0);
    assign byte_ev   = (bit_take && rx_cnt_q == RX_LAST_BIT)
                       || (bit_send && tx_cnt_q == 4'h_1 && !tx_is_crc_q);
    assign byte_val  = bit_take ? {i_dq, rx_sh_q[7:1]} : tx_byte_q;

    swsl_fifo #(.W(8), .D(8)) swsl_fifo_i (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_in_data   (i_tx_data),
        .i_in_valid  (i_tx_valid),
        .o_in_ready  (o_tx_ready),
        .o_out_data  (fifo_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop)
    );

    // strap caught after reset release, never inside the reset branch
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            cap_q       <= 1'b0;
            o_concealed <= 1'b0;
        end
        else if (!cap_q)
        begin
            cap_q       <= 1'b1;
            o_concealed <= (i_src_sel == CONCEAL_SEL);
        end
    end

    // line state machine: reset, presence, slot timing
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            st_q        <= SWSL_IDLE;
            cnt_q       <= '0;
            dq_prev_q   <= 1'b1;
            low_run_q   <= 1'b0;
            rst_seen_q  <= 1'b0;
            pres_done_q <= 1'b0;
            o_rom_ready <= 1'b0;
        end
        else
        begin
            dq_prev_q   <= i_dq;
            o_rom_ready <= 1'b0;
            cnt_q       <= (&cnt_q) ? cnt_q : CNT_W'(cnt_q + 1'b1);
            case (st_q)
                SWSL_IDLE:
                begin
                    if (fall)
                    begin
                        st_q      <= SWSL_SLOT;
                        cnt_q     <= '0;
                        low_run_q <= 1'b1;
                    end
                end
                SWSL_SLOT:
                begin
                    if (i_dq)
                    begin
                        low_run_q <= 1'b0;
                    end
                    if (low_run_q && !i_dq
                        && cnt_q == CNT_W'(RST_CYC - 1))
                    begin
                        rst_seen_q <= 1'b1;
                    end
                    if (i_dq && rst_seen_q)
                    begin
                        st_q       <= SWSL_PWAIT;
                        cnt_q      <= '0;
                        rst_seen_q <= 1'b0;
                    end
                    else if (i_dq && slot_done)
                    begin
                        st_q <= SWSL_IDLE;
                    end
                end
                SWSL_PWAIT:
                begin
                    if (cnt_q == CNT_W'(PWAIT_CYC - 1))
                    begin
                        cnt_q <= '0;
                        if (pres_ok)
                        begin
                            st_q <= SWSL_PRES;
                        end
                        else
                        begin
                            st_q        <= SWSL_IDLE;
                            o_rom_ready <= 1'b1;
                        end
                    end
                end
                SWSL_PRES:
                begin
                    if (cnt_q == CNT_W'(PRES_CYC - 1))
                    begin
                        st_q        <= SWSL_IDLE;
                        pres_done_q <= 1'b1;
                        o_rom_ready <= 1'b1;
                    end
                end
                default:
                begin
                    st_q <= SWSL_IDLE;
                end
            endcase
        end
    end

    // drive low only for presence or a read-zero bit
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_dq    <= 1'b0;
            o_dq_oe <= 1'b0;
        end
        else
        begin
            o_dq    <= 1'b0;
            o_dq_oe <= (st_q == SWSL_PRES)
                       || ((st_q == SWSL_SLOT) && tx_act && !tx_sh_q[0]
                           && cnt_q < CNT_W'(HLD_CYC));
        end
    end

    // transmit shifter: pending crc bytes go before fifo data
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || o_rom_ready)
        begin
            tx_sh_q     <= '0;
            tx_byte_q   <= '0;
            tx_cnt_q    <= '0;
            tx_is_crc_q <= 1'b0;
        end
        else if (bit_send)
        begin
            tx_sh_q  <= tx_sh_q >> 1;
            tx_cnt_q <= tx_cnt_q - 1'b1;
        end
        else if (st_q == SWSL_IDLE && !tx_act && pend_q != '0)
        begin
            tx_sh_q     <= (pend_q == CRC_BYTES) ? crc_out_q[7:0]
                                                 : crc_out_q[15:8];
            tx_cnt_q    <= BITS_PER_BYTE;
            tx_is_crc_q <= 1'b1;
        end
        else if (fifo_pop && fifo_valid)
        begin
            tx_sh_q     <= fifo_data;
            tx_byte_q   <= fifo_data;
            tx_cnt_q    <= BITS_PER_BYTE;
            tx_is_crc_q <= 1'b0;
        end
    end

    // receive shifter, lsb first
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || o_rom_ready)
        begin
            rx_cnt_q   <= '0;
            rx_sh_q    <= '0;
            o_rx_data  <= '0;
            o_rx_valid <= 1'b0;
        end
        else
        begin
            o_rx_valid <= 1'b0;
            if (bit_take)
            begin
                rx_sh_q  <= {i_dq, rx_sh_q[7:1]};
                rx_cnt_q <= rx_cnt_q + 1'b1;
                if (rx_cnt_q == RX_LAST_BIT)
                begin
                    o_rx_data  <= {i_dq, rx_sh_q[7:1]};
                    o_rx_valid <= 1'b1;
                end
            end
        end
    end

    // crc16 generator; a byte landing with a clear shifts into the
    // cleared value so it is not lost. no compare path exists at all.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            crc_q     <= CRC16_INIT;
            crc_out_q <= '0;
            pend_q    <= '0;
        end
        else
        begin
            if (i_crc_load)
            begin
                crc_q <= i_crc_load_val;
            end
            else if (i_crc_clr || send_go)
            begin
                crc_q <= byte_ev ? crc16_byte(CRC16_INIT, byte_val)
                                 : CRC16_INIT;
            end
            else if (byte_ev)
            begin
                crc_q <= crc16_byte(crc_q, byte_val);
            end
            if (send_go)
            begin
                crc_out_q <= ~crc_q;
                pend_q    <= CRC_BYTES;
            end
            else if (bit_send && tx_cnt_q == 4'h_1 && tx_is_crc_q)
            begin
                pend_q <= pend_q - 1'b1;
            end
        end
    end

    // channel crc interval counter
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || o_rom_ready)
        begin
            chan_on_q  <= 1'b0;
            chan_sel_q <= SWSL_CRC_NONE;
            byte_cnt_q <= '0;
            auto_due_q <= 1'b0;
        end
        else
        begin
            auto_due_q <= 1'b0;
            if (i_chan_start)
            begin
                chan_on_q  <= 1'b1;
                chan_sel_q <= i_chan_sel;
                byte_cnt_q <= '0;
            end
            else if (chan_on_q && byte_ev
                     && interval_len(chan_sel_q) != '0)
            begin
                if (byte_cnt_q + BYTE_CNT_ONE == interval_len(chan_sel_q))
                begin
                    byte_cnt_q <= '0;
                    auto_due_q <= 1'b1;
                end
                else
                begin
                    byte_cnt_q <= byte_cnt_q + BYTE_CNT_ONE;
                end
            end
        end
    end

    // identity crc8, sent as is
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_id_crc8 <= CRC8_INIT;
        end
        else
        begin
            logic [7:0] c;
            c = CRC8_INIT;
            for (int i = 0; i < ID_BITS; i++)
            begin
                c = (c[0] ^ i_id[i]) ? ((c >> 1) ^ CRC8_POLY) : (c >> 1);
            end
            o_id_crc8 <= c;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_reset_rise;
        st_q == SWSL_SLOT && rst_seen_q && i_dq;
    endsequence
    sequence s_pres_end;
        st_q == SWSL_PRES && cnt_q == CNT_W'(PRES_CYC - 1);
    endsequence

    chk_reset_to_wait: assert property (s_reset_rise |=> st_q == SWSL_PWAIT)
        else $error("rise after reset did not start presence wait");
    chk_presence_end: assert property (s_pres_end |=> o_rom_ready
                                       ##1 !o_dq_oe)
        else $error("presence did not end on time");
    chk_presence_oe: assert property (st_q == SWSL_PRES |=> o_dq_oe)
        else $error("presence not driven");
    chk_conceal_once: assert property (o_concealed && pres_done_q
                                       |-> st_q != SWSL_PRES)
        else $error("concealed device repeated presence");
    chk_write_sample: assert property (bit_take |=> rx_sh_q[7]
                                       == $past(i_dq))
        else $error("write bit taken off the sample point");
    chk_read_one: assert property (st_q == SWSL_SLOT && tx_act
                                   && tx_sh_q[0] ##1 st_q == SWSL_SLOT
                                   |-> !o_dq_oe)
        else $error("read one drove the line");
    chk_read_hold: assert property ($fell(o_dq_oe) && $past(st_q)
                                    == SWSL_SLOT |-> cnt_q
                                    == CNT_W'(HLD_CYC + 1) || i_rst)
        else $error("read zero hold wrong length");
    chk_crc_invert: assert property (send_go |=> crc_out_q == ~$past(crc_q)
                                     ##1 pend_q == CRC_BYTES)
        else $error("crc not latched complemented");
    chk_crc_clear: assert property (send_go && !i_crc_load && !byte_ev
                                    |=> crc_q == CRC16_INIT)
        else $error("crc not cleared after send");
    chk_crc_load: assert property (i_crc_load |=> crc_q
                                   == $past(i_crc_load_val))
        else $error("crc address load failed");
endmodule

// ### rtl/swsl_pkg.sv
/*
 * package for the single-wire slave link: timing figures, counter widths,
 * crc polynomials and channel crc interval codes.
 * assumes a 200 MHz reference clock; times are kept in microseconds.
 */
package swsl_pkg;
    localparam int CLK_MHZ           = 200;
    // least master reset low time; presence figures chosen inside 15-60/60-240
    localparam int RESET_LOW_US      = 480;
    localparam int PRESENCE_WAIT_US  = 30;
    localparam int PRESENCE_LOW_US   = 120;
    // internal slot delays: write sample point and read-zero hold time
    localparam int SAMPLE_US         = 30;
    localparam int HOLD_US           = 30;
    localparam int RESET_LOW_CYC     = RESET_LOW_US * CLK_MHZ;
    localparam int PRESENCE_WAIT_CYC = PRESENCE_WAIT_US * CLK_MHZ;
    localparam int PRESENCE_LOW_CYC  = PRESENCE_LOW_US * CLK_MHZ;
    localparam int SAMPLE_CYC        = SAMPLE_US * CLK_MHZ;
    localparam int HOLD_CYC          = HOLD_US * CLK_MHZ;
    localparam int CNT_W             = 17;
    localparam int ID_BITS           = 56;
    // reflected forms of x^16+x^15+x^2+1 and x^8+x^5+x^4+1
    localparam logic [15:0] CRC16_POLY = 16'h_A001;
    localparam logic [7:0]  CRC8_POLY  = 8'h_8C;
    localparam logic [15:0] CRC16_INIT = 16'h_0000;
    localparam logic [7:0]  CRC8_INIT  = 8'h_00;
    localparam logic [1:0]  CONCEAL_SEL = 2'h_0;
    localparam logic [5:0]  BYTE_CNT_ONE = 6'h_01;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h_8;
    localparam logic [2:0]  RX_LAST_BIT = 3'h_7;
    localparam logic [1:0]  CRC_BYTES = 2'h_2;
    typedef enum logic [1:0] {
        SWSL_CRC_NONE,
        SWSL_CRC_EVERY_1,
        SWSL_CRC_EVERY_8,
        SWSL_CRC_EVERY_32
    } swsl_crc_sel_type;
    localparam logic [5:0] INTERVAL_1  = 6'h_01;
    localparam logic [5:0] INTERVAL_8  = 6'h_08;
    localparam logic [5:0] INTERVAL_32 = 6'h_20;
endpackage
